// ---- tcc_pkg.sv ----
// Constants shared by the timer channel control block
package tcc_pkg;

	localparam int TCC_NCH = 6;

	localparam logic [7:0] TCC_CTRL_OFS = 8'h20;
	localparam logic [7:0] TCC_CNTH_OFS = 8'h21;
	localparam logic [7:0] TCC_CNTL_OFS = 8'h22;
	localparam logic [7:0] TCC_MODH_OFS = 8'h24;
	localparam logic [7:0] TCC_MODL_OFS = 8'h25;
	localparam logic [7:0] TCC_CH0_OFS = 8'h26;
	localparam logic [7:0] TCC_CH_STRIDE = 8'h03;
	localparam logic [7:0] TCC_HI_OFS = 8'h01;
	localparam logic [7:0] TCC_LO_OFS = 8'h02;

	localparam int TCC_B_FLAG = 7;
	localparam int TCC_B_IE = 6;
	localparam int TCC_B_BSEL = 5;
	localparam int TCC_B_MSA = 4;
	localparam int TCC_B_ELSB = 3;
	localparam int TCC_B_ELSA = 2;
	localparam int TCC_B_TOV = 1;
	localparam int TCC_B_MAX = 0;

	localparam int TCC_B_WRAP = 7;
	localparam int TCC_B_HALT = 5;
	localparam int TCC_B_CLR = 4;

	localparam logic [15:0] TCC_MOD_RESET = 16'hFFFF;
	localparam logic [15:0] TCC_CNT_RESET = 16'h0000;
	localparam logic [1:0] TCC_ELS_OFF = 2'h0;
	localparam logic [1:0] TCC_ELS_TOGGLE = 2'h1;
	localparam logic [1:0] TCC_ELS_CLEAR = 2'h2;
	localparam logic [1:0] TCC_ELS_SET = 2'h3;

	typedef enum logic [1:0] {
		TCC_PRESET,
		TCC_CAPTURE,
		TCC_COMPARE,
		TCC_BUFFERED
	} tcc_mode_t;

endpackage

// ---- tcc_edge_detect.sv ----
// Active-edge detector for one capture input
`timescale 1ns/1ps
module tcc_edge_detect
	import tcc_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic pinIn,
	input wire logic [1:0] edgeSel,
	output logic edgeSeen
);

	logic prevPin_r;
	wire rise = pinIn & ~prevPin_r;
	wire fall = ~pinIn & prevPin_r;

	// Pin tracked always, so enabling capture never sees a stale edge
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			prevPin_r <= 1'b0;
		end else begin
			prevPin_r <= pinIn;
		end
	end

	assign edgeSeen = (edgeSel[0] & rise) | (edgeSel[1] & fall);

endmodule

// ---- tcc_event_flag.sv ----
// Channel event flag; read-then-write-zero clear is guarded only while the interrupt is enabled
`timescale 1ns/1ps
module tcc_event_flag
	import tcc_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic setEvt,
	input wire logic irqEn,
	input wire logic statRead,
	input wire logic statWrite,
	input wire logic wrFlagBit,
	output logic flag
);

	logic flag_r;
	logic armed_r;
	wire clearOk;

	// Without the enable a plain zero write clears
	assign clearOk = statWrite & ~wrFlagBit & (~irqEn | armed_r);

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			flag_r <= 1'b0;
			armed_r <= 1'b0;
		end else begin
			// Set wins; writing one never sets
			flag_r <= setEvt | (flag_r & ~clearOk);
			if (setEvt) begin
				armed_r <= 1'b0;
			end else if (statRead & flag_r) begin
				armed_r <= 1'b1;
			end else if (statWrite) begin
				armed_r <= 1'b0;
			end
		end
	end

	assign flag = flag_r;

endmodule

// ---- tcc_timer_channels.sv ----
// Six-channel timer: counter, channel control, capture and compare outputs
`timescale 1ns/1ps
module tcc_timer_channels
	import tcc_pkg::*;
#(
	parameter int NCH = TCC_NCH
)
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrEn,
	input wire logic regRdEn,
	output logic [7:0] regRdData,
	input wire logic [NCH-1:0] chanPinIn,
	output logic [NCH-1:0] chanPinOut,
	output logic [NCH-1:0] chanPinOe,
	output logic [NCH-1:0] chanConnect,
	output logic timerIrq
);

	logic [15:0] cnt_r;
	logic [15:0] mod_r;
	logic [7:0] modHiBuf_r;
	logic modHold_r;
	logic halt_r;
	logic wrapFlag_r;
	logic [7:0] rdData_r;
	logic irq_r;

	wire hitCtrl = regAddr == TCC_CTRL_OFS;
	wire hitCntH = regAddr == TCC_CNTH_OFS;
	wire hitCntL = regAddr == TCC_CNTL_OFS;
	wire hitModH = regAddr == TCC_MODH_OFS;
	wire hitModL = regAddr == TCC_MODL_OFS;
	wire wrCtrl = regWrEn & hitCtrl;
	wire tick = ~halt_r;
	// Inhibited after a modulo high write, so no wrap on a half value
	wire wrap = tick & (cnt_r == mod_r) & ~modHold_r;
	wire cntClr = wrCtrl & regWrData[TCC_B_CLR];
	wire wrapClr = wrCtrl & ~regWrData[TCC_B_WRAP];

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_r <= TCC_CNT_RESET;
		end else if (cntClr | wrap) begin
			cnt_r <= TCC_CNT_RESET;
		end else if (tick) begin
			cnt_r <= cnt_r + 16'h0001;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			halt_r <= 1'b0;
			wrapFlag_r <= 1'b0;
		end else begin
			if (wrCtrl) begin
				halt_r <= regWrData[TCC_B_HALT];
			end
			wrapFlag_r <= wrap | (wrapFlag_r & ~wrapClr);
		end
	end

	// Modulo is taken whole at the low write
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			mod_r <= TCC_MOD_RESET;
			modHiBuf_r <= TCC_MOD_RESET[15:8];
			modHold_r <= 1'b0;
		end else if (regWrEn & hitModH) begin
			modHiBuf_r <= regWrData;
			modHold_r <= 1'b1;
		end else if (regWrEn & hitModL) begin
			mod_r <= {modHiBuf_r, regWrData};
			modHold_r <= 1'b0;
		end
	end

	wire [7:0] ctrlRd = {wrapFlag_r, 1'b0, halt_r, 5'h00};

	logic [NCH-1:0] chHit;
	logic [7:0] chRd [NCH];
	logic [NCH-1:0] irqReq;
	logic [NCH-1:0] bufMode;
	logic [15:0] val [NCH];
	logic [NCH-1:0] cmpHold;

	genvar i;
	generate
		for (i = 0; i < NCH; i++) begin : g_ch
			localparam logic [7:0] BASE = 8'(TCC_CH0_OFS + TCC_CH_STRIDE * i);

			logic ie_r;
			logic msA_r;
			logic [1:0] els_r;
			logic tov_r;
			logic max_r;
			logic maxEff_r;
			logic out_r;
			logic oe_r;
			logic con_r;
			logic capHold_r;
			logic cmpHold_r;
			logic [15:0] val_r;
			logic flag;
			logic edgeSeen;
			logic disabled;
			logic [15:0] cmpVal;
			logic out_nxt;
			tcc_mode_t mode;

			wire hitStat = regAddr == BASE;
			wire hitHi = regAddr == 8'(BASE + TCC_HI_OFS);
			wire hitLo = regAddr == 8'(BASE + TCC_LO_OFS);
			wire statWr = regWrEn & hitStat & ~disabled;
			wire statRd = regRdEn & hitStat;

			// Odd channel gives way to its buffered even partner
			if (i % 2 == 1) begin : g_odd
				assign disabled = bufMode[i-1];
				assign bufMode[i] = 1'b0;
				assign cmpVal = val_r;
			end else begin : g_even
				logic bsel_r;
				logic alt_r;
				always_ff @(posedge core_clk or negedge reset_n) begin
					if (!reset_n) begin
						bsel_r <= 1'b0;
						alt_r <= 1'b0;
					end else begin
						if (statWr) begin
							bsel_r <= regWrData[TCC_B_BSEL];
						end
						if (!bsel_r) begin
							alt_r <= 1'b0;
						end else if (wrap) begin
							alt_r <= ~alt_r;
						end
					end
				end
				assign disabled = 1'b0;
				assign bufMode[i] = bsel_r;
				// Last even channel has no partner when NCH is odd
				if (i + 1 < NCH) begin : g_pair
					assign cmpVal = alt_r ? val[i+1] : val_r;
				end else begin : g_solo
					assign cmpVal = val_r;
				end
			end

			// Mode decode from mode and edge fields
			always_comb begin
				if (els_r == TCC_ELS_OFF) begin
					mode = TCC_PRESET;
				end else if (bufMode[i]) begin
					mode = TCC_BUFFERED;
				end else if (msA_r) begin
					mode = TCC_COMPARE;
				end else begin
					mode = TCC_CAPTURE;
				end
			end

			wire active = ~disabled;
			wire isCap = active & (mode == TCC_CAPTURE);
			wire isCmp = active & (mode == TCC_COMPARE || mode == TCC_BUFFERED);
			wire clrMode = els_r == TCC_ELS_CLEAR;
			wire holdAny = (mode == TCC_BUFFERED) ? (cmpHold_r | cmpHold[i^1]) : cmpHold_r;
			wire cmpHit = isCmp & tick & (cnt_r == cmpVal) & ~holdAny;
			wire capEvt = isCap & edgeSeen & ~capHold_r;
			wire ovTog = isCmp & wrap & tov_r;
			wire maxNew = max_r & tov_r & clrMode;

			tcc_edge_detect u_edge (
				.core_clk(core_clk),
				.reset_n(reset_n),
				.pinIn(chanPinIn[i]),
				.edgeSel(els_r),
				.edgeSeen(edgeSeen)
			);

			tcc_event_flag u_flag (
				.core_clk(core_clk),
				.reset_n(reset_n),
				.setEvt(capEvt | cmpHit),
				.irqEn(ie_r),
				.statRead(statRd),
				.statWrite(statWr),
				.wrFlagBit(regWrData[TCC_B_FLAG]),
				.flag(flag)
			);

			// Output level: overflow first, then compare action
			always_comb begin
				out_nxt = out_r;
				if (mode == TCC_PRESET) begin
					out_nxt = ~msA_r;
				end else if (ovTog) begin
					// Entering or leaving full duty restarts the period high
					out_nxt = (maxNew | maxEff_r) ? 1'b1 : ~out_r;
				end else if (cmpHit & ~maxEff_r) begin
					unique case (els_r)
						TCC_ELS_TOGGLE: out_nxt = ~out_r;
						TCC_ELS_CLEAR: out_nxt = 1'b0;
						TCC_ELS_SET: out_nxt = 1'b1;
						default: out_nxt = out_r;
					endcase
				end
			end

			always_ff @(posedge core_clk or negedge reset_n) begin
				if (!reset_n) begin
					ie_r <= 1'b0;
					msA_r <= 1'b0;
					els_r <= TCC_ELS_OFF;
					tov_r <= 1'b0;
					max_r <= 1'b0;
				end else if (statWr) begin
					ie_r <= regWrData[TCC_B_IE];
					msA_r <= regWrData[TCC_B_MSA];
					els_r <= regWrData[TCC_B_ELSB:TCC_B_ELSA];
					tov_r <= regWrData[TCC_B_TOV];
					max_r <= regWrData[TCC_B_MAX];
				end
			end

			always_ff @(posedge core_clk or negedge reset_n) begin
				if (!reset_n) begin
					maxEff_r <= 1'b0;
					out_r <= 1'b1;
					oe_r <= 1'b0;
					con_r <= 1'b0;
				end else begin
					if (~isCmp) begin
						maxEff_r <= 1'b0;
					end else if (wrap) begin
						maxEff_r <= maxNew;
					end
					out_r <= out_nxt;
					con_r <= active & (mode != TCC_PRESET);
					oe_r <= isCmp;
				end
			end

			// Value write high byte holds compares; capture read high holds captures
			always_ff @(posedge core_clk or negedge reset_n) begin
				if (!reset_n) begin
					val_r <= 16'h0000;
					cmpHold_r <= 1'b0;
					capHold_r <= 1'b0;
				end else begin
					if (regWrEn & hitHi) begin
						val_r[15:8] <= regWrData;
						cmpHold_r <= mode != TCC_CAPTURE;
					end else if (regWrEn & hitLo) begin
						val_r[7:0] <= regWrData;
						cmpHold_r <= 1'b0;
					end else if (capEvt) begin
						val_r <= cnt_r;
					end
					if (regRdEn & hitHi & isCap) begin
						capHold_r <= 1'b1;
					end else if (regRdEn & hitLo) begin
						capHold_r <= 1'b0;
					end
				end
			end

			wire [7:0] statRdv = {flag, ie_r, bufMode[i], msA_r, els_r, tov_r, max_r};

			assign val[i] = val_r;
			assign cmpHold[i] = cmpHold_r;
			assign irqReq[i] = flag & ie_r & active;
			assign chHit[i] = hitStat | hitHi | hitLo;
			assign chRd[i] = hitStat ? statRdv : (hitHi ? val_r[15:8] : val_r[7:0]);
			assign chanPinOut[i] = out_r;
			assign chanPinOe[i] = oe_r;
			assign chanConnect[i] = con_r;
		end
	endgenerate

	logic [7:0] rdMux;

	// Unmapped addresses read as zero
	always_comb begin
		rdMux = 8'h00;
		if (hitCtrl) begin
			rdMux = ctrlRd;
		end else if (hitCntH) begin
			rdMux = cnt_r[15:8];
		end else if (hitCntL) begin
			rdMux = cnt_r[7:0];
		end else if (hitModH) begin
			rdMux = mod_r[15:8];
		end else if (hitModL) begin
			rdMux = mod_r[7:0];
		end
		for (int k = 0; k < NCH; k++) begin
			if (chHit[k]) begin
				rdMux = chRd[k];
			end
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rdData_r <= 8'h00;
			irq_r <= 1'b0;
		end else begin
			if (regRdEn) begin
				rdData_r <= rdMux;
			end
			irq_r <= |irqReq;
		end
	end

	assign regRdData = rdData_r;
	assign timerIrq = irq_r;

endmodule

// ---- tcc_assertions.sv ----
// Port-level checker for the timer channel block
`timescale 1ns/1ps
module tcc_assertions
	import tcc_pkg::*;
#(
	parameter int NCH = TCC_NCH
)
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire logic [7:0] regRdData,
	input wire logic [NCH-1:0] chanPinIn,
	input wire logic [NCH-1:0] chanPinOut,
	input wire logic [NCH-1:0] chanPinOe,
	input wire logic [NCH-1:0] chanConnect,
	input wire logic timerIrq
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);

	reset_state_a: assert property ($rose(reset_n) |-> chanConnect == '0 && !timerIrq)
		else $error("channels not idle after reset");
	oe_needs_conn_a: assert property ((chanPinOe & ~chanConnect) == '0)
		else $error("pin driven while not connected");
	irq_fall_a: assert property ($fell(timerIrq) |-> $past(regWrEn) || $past(regWrEn, 2))
		else $error("interrupt dropped without a write");
	unmapped_rd_a: assert property (regRdEn && regAddr < 8'h20 |=> regRdData == 8'h00)
		else $error("unmapped read not zero");
	odd_bsel_a: assert property (regRdEn && (regAddr == 8'h29 || regAddr == 8'h2F
		|| regAddr == 8'h35) |=> !regRdData[5])
		else $error("odd channel shows buffered bit");
	conn_write_a: assert property ($changed(chanConnect) |-> $past(regWrEn)
		|| $past(regWrEn, 2))
		else $error("connection changed without a write");
	rd_hold_a: assert property (!$past(regRdEn) |-> $stable(regRdData))
		else $error("read data moved without a read");
	preset_hold_a: assert property (((~chanConnect & ~$past(chanConnect)
		& (chanPinOut ^ $past(chanPinOut))) != '0) |-> $past(regWrEn) || $past(regWrEn, 2))
		else $error("disconnected output moved");
endmodule

// ---- tcc_pin_model.sv ----
// Far-side pin model: resolves each channel pin from both drivers
`timescale 1ns/1ps
module tcc_pin_model
	import tcc_pkg::*;
#(
	parameter int NCH = 6
)
(
	input wire logic [NCH-1:0] pinOut,
	input wire logic [NCH-1:0] pinOe,
	input wire logic [NCH-1:0] drvLevel,
	output logic [NCH-1:0] pinIn
);
	// External driver yields wherever the timer drives the pin
	assign pinIn = (pinOe & pinOut) | (~pinOe & drvLevel);
endmodule

// ---- timer_channel_mode_control_test.sv ----
// Self-checking bench for the timer channel block
`timescale 1ns/1ps
module timer_channel_mode_control_test;
	import tcc_pkg::*;
	localparam int NCH = TCC_NCH;
	logic core_clk = 0;
	logic reset_n = 0;
	logic [7:0] regAddr = 8'h00;
	logic [7:0] regWrData = 8'h00;
	logic regWrEn = 0;
	logic regRdEn = 0;
	logic [7:0] regRdData;
	logic [NCH-1:0] chanPinIn, chanPinOut, chanPinOe, chanConnect;
	logic [NCH-1:0] pinDrv = '0;
	logic timerIrq;
	logic [7:0] d, a;
	int badCount = 0;
	int cmpCount = 0;
	int cycles = 0;

	always #4 core_clk = ~core_clk;

	tcc_timer_channels #(.NCH(NCH)) dut_u (.core_clk(core_clk), .reset_n(reset_n),
		.regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
		.regRdData(regRdData), .chanPinIn(chanPinIn), .chanPinOut(chanPinOut),
		.chanPinOe(chanPinOe), .chanConnect(chanConnect), .timerIrq(timerIrq));
	tcc_pin_model #(.NCH(NCH)) pin_u (.pinOut(chanPinOut), .pinOe(chanPinOe),
		.drvLevel(pinDrv), .pinIn(chanPinIn));

	task report_and_stop;
		if (badCount == 0 && cmpCount > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			badCount = badCount + 1;
			report_and_stop;
		end
	end

	task chk(input string n, input logic [7:0] s, input logic [7:0] e);
		cmpCount = cmpCount + 1;
		if (s !== e) begin
			badCount = badCount + 1;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task wt(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task wr(input logic [7:0] ad, input logic [7:0] dt);
		@(posedge core_clk);
		regAddr <= ad;
		regWrData <= dt;
		regWrEn <= 1;
		@(posedge core_clk);
		regWrEn <= 0;
	endtask
	task rd(input logic [7:0] ad, output logic [7:0] dt);
		@(posedge core_clk);
		regAddr <= ad;
		regRdEn <= 1;
		@(posedge core_clk);
		regRdEn <= 0;
		#1 dt = regRdData;
	endtask

	task t_reset;
		#1 chk("conn", chanConnect, 0);
		chk("oe", chanPinOe, 0);
		chk("out", chanPinOut, 8'h3F);
		rd(8'h35, d);
		chk("stat5", d, 8'h00);
		rd(8'h10, d);
		chk("unmapped", d, 8'h00);
		wr(8'h2F, 8'h10);
		wt(2);
		chk("preset", {chanPinOut[3], chanConnect[3]}, 0);
	endtask

	task t_capture;
		for (int c = 1; c < 4; c++) begin
			wt(3);
			wr(8'h2C, 8'(c << 2));
			// Connection is registered behind the control bits
			wt(2);
			chk("conn2", {chanConnect[2], chanPinOe[2]}, 2);
			pinDrv[2] <= 1;
			wt(4);
			rd(8'h2C, d);
			chk("rise", d[7], 8'(c & 1));
			wr(8'h2C, 8'(c << 2));
			pinDrv[2] <= 0;
			wt(4);
			rd(8'h2C, d);
			chk("fall", d[7], 8'(c >> 1));
			wr(8'h2C, 8'h00);
		end
	endtask

	task t_clear;
		wr(8'h2C, 8'h4C);
		pinDrv[2] <= 1;
		wt(4);
		chk("irq", timerIrq, 1);
		wr(8'h2C, 8'h4C);
		rd(8'h2C, d);
		chk("noread", d, 8'hCC);
		pinDrv[2] <= 0;
		wt(4);
		wr(8'h2C, 8'h4C);
		rd(8'h2C, d);
		chk("newevt", d, 8'hCC);
		wr(8'h2C, 8'hCC);
		rd(8'h2C, d);
		chk("wrone", d, 8'hCC);
		wr(8'h2C, 8'h4C);
		rd(8'h2C, d);
		chk("cleared", d, 8'h4C);
		wr(8'h2C, 8'h0C);
		pinDrv[2] <= 1;
		wt(4);
		chk("irqoff", timerIrq, 0);
	endtask

	task t_compare;
		wr(8'h24, 8'h00);
		wr(8'h25, 8'h0F);
		// Counter is far above the new modulo; restart it before any mode change
		wr(8'h20, 8'h10);
		wr(8'h27, 8'h00);
		wr(8'h28, 8'h05);
		wr(8'h26, 8'h18);
		wt(20);
		chk("clr", {chanPinOe[0], chanPinOut[0]}, 2);
		rd(8'h20, d);
		chk("wrap", d, 8'h80);
		rd(8'h26, d);
		chk("cmpflag", d, 8'h98);
		wr(8'h26, 8'h1C);
		wt(20);
		chk("set", chanPinOut[0], 1);
		wr(8'h26, 8'h14);
		wt(20);
		a[0] = chanPinOut[0];
		wt(16);
		chk("toggle", chanPinOut[0], !a[0]);
		wr(8'h27, 8'h00);
		a[0] = chanPinOut[0];
		wt(16);
		chk("hionly", chanPinOut[0], a[0]);
	endtask

	task t_duty;
		wr(8'h33, 8'h00);
		wr(8'h34, 8'h05);
		wr(8'h32, 8'h1B);
		wt(40);
		for (int i = 0; i < 16; i++) begin
			wt(1);
			chk("full", chanPinOut[4], 1);
		end
		wr(8'h32, 8'h1A);
		wt(40);
		a = 0;
		for (int i = 0; i < 16; i++) begin
			wt(1);
			a = a | 8'(!chanPinOut[4]);
		end
		chk("duty off", a, 1);
	endtask

	task t_buffered;
		wr(8'h29, 8'h04);
		wt(2);
		chk("conn1", chanConnect[1], 1);
		wr(8'h26, 8'h38);
		wt(2);
		chk("freed", chanConnect[1], 0);
		rd(8'h26, d);
		chk("bsel", d[5], 1);
		wr(8'h29, 8'h24);
		rd(8'h29, d);
		chk("oddreg", d, 8'h04);
	endtask

	initial begin
		wt(20);
		reset_n <= 1;
		wt(1);
		t_reset;
		t_capture;
		t_clear;
		t_compare;
		t_duty;
		t_buffered;
		report_and_stop;
	end
endmodule

bind tcc_timer_channels tcc_assertions #(.NCH(NCH)) chk_u (.core_clk(core_clk),
	.reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
	.regRdEn(regRdEn), .regRdData(regRdData), .chanPinIn(chanPinIn),
	.chanPinOut(chanPinOut), .chanPinOe(chanPinOe), .chanConnect(chanConnect),
	.timerIrq(timerIrq));
